/* rtl/hpsd_pkg.sv */
// Package for the host port and status display block: register map, field positions,
// reset values, counter thresholds, display scan limits and state codes.
// Assumes a single 10 MHz device clock and a 5-bit address, 8-bit data host port.

package hpsd_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [4:0] HPSD_OFS_CONTROL    = 5'h00;  // Page select and counter options.
  localparam logic [4:0] HPSD_OFS_COUNT_MASK = 5'h01;  // Events that step the counters.
  localparam logic [4:0] HPSD_OFS_REC_MASK   = 5'h02;  // Events that set record bits.
  localparam logic [4:0] HPSD_OFS_IRQ_MASK   = 5'h03;  // Sources allowed onto the interrupt.
  localparam logic [4:0] HPSD_OFS_STATUS     = 5'h04;  // Live interrupt source state.
  localparam logic [4:0] HPSD_OFS_ARRAY      = 5'h06;  // First counter byte or record register.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int HPSD_CTL_PAGE_BIT  = 0;  // 0: counter array, 1: record array.
  localparam int HPSD_CTL_ROR_BIT   = 1;  // Clear a counter once it is read.
  localparam int HPSD_CTL_FWF_BIT   = 2;  // Freeze a counter at full.
  localparam int HPSD_IRQ_FULL_BIT  = 0;
  localparam int HPSD_IRQ_HIGH_BIT  = 1;
  localparam int HPSD_IRQ_LOW_BIT   = 2;
  localparam int HPSD_IRQ_REC_BIT   = 3;

  // ****************************************************************
  // Reset values and thresholds.
  // ****************************************************************
  localparam logic [7:0]  HPSD_CONTROL_RST = 8'h00;
  localparam logic [7:0]  HPSD_MASK_RST    = 8'h00;  // All events disabled after reset.
  localparam logic [15:0] HPSD_CNT_RST     = 16'h0000;
  localparam logic [15:0] HPSD_CNT_FULL    = 16'hFFFF;
  localparam logic [15:0] HPSD_CNT_HIGH    = 16'hC000;
  localparam logic [15:0] HPSD_CNT_LOW     = 16'h00FF;

  // ****************************************************************
  // Display scan: bank A has 8 latch addresses, bank B has 6.
  // ****************************************************************
  localparam logic [3:0] HPSD_SCAN_BANK_B = 4'h8;
  localparam logic [3:0] HPSD_SCAN_LAST   = 4'hD;

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  typedef enum logic [2:0] {
    HPSD_DSP_SETUP  = 3'h0,
    HPSD_DSP_STROBE = 3'h1,
    HPSD_DSP_HOLD   = 3'h2,
    HPSD_ACC_START  = 3'h3,
    HPSD_ACC_WAIT   = 3'h4
  } hpsd_state_type;

endpackage : hpsd_pkg

/* rtl/hpsd_top.sv */
// Host port and LED status display sequencer of a multiport repeater, with per-port
// event counters, event record registers, event interrupt and a serial status stream.
// Assumes an external bidirectional transceiver between the data pins and the host bus,
// host glue that makes the read and write strobes, and port status from on-chip logic.
//
// How it works
// - Registers reached by 5-bit address, 8-bit data.
// - Display cycles drive latch address and status.
// - Device drives data bus during display cycles.
// - Finish display cycle, then enable the transceiver.
// - Write cycles turn the data drivers off.
// - D0-D4: link, collision, receive, isolated, polarity.
// - Bank A 000 globals, 001 port one onward.
// - Bank B 000-101 ports 8-13, rest unused.
// - Polarity indicator follows inverted receive detection.
// - Each port has record register and 16-bit counter.
// - Masks select counted and recorded events.
// - Event conditions assert the low interrupt output.
// - Status is sent serially on management output.

`timescale 1ns/100ps

module hpsd_top
  import hpsd_pkg::*;
#(
  parameter int NPORT = 13,
  parameter int NEV   = 8
) (
  // Clock and reset.
  input  wire logic               CLOCK_IN,
  input  wire logic               RSTN_IN,
  // Host port pins.
  input  wire logic [4:0]         ADDR_IN,
  input  wire logic               RD_N_IN,
  input  wire logic               WR_N_IN,
  input  wire logic [7:0]         DATA_IN,
  output logic      [7:0]         DATA_OUT,
  output logic                    DATA_OE_N_OUT,
  output logic                    TRANSCEIVER_ENABLE_N_OUT,
  // Display latch strobes.
  output logic                    FIRST_BANK_LATCH_STROBE_N_OUT,
  output logic                    SECOND_BANK_LATCH_STROBE_N_OUT,
  // Port status from the repeater core.
  input  wire logic [NPORT-1:0]   PORT_LINK_IN,
  input  wire logic [NPORT-1:0]   PORT_COLLISION_IN,
  input  wire logic [NPORT-1:0]   PORT_RECEIVE_IN,
  input  wire logic [NPORT-1:0]   PORT_ISOLATED_IN,
  input  wire logic [NPORT-1:0]   PORT_REVERSED_POLARITY_IN,
  input  wire logic               GLOBAL_BABBLE_IN,
  // Per-port network events, valid in the cycle of the end-of-packet strobe.
  input  wire logic [NPORT*NEV-1:0] PORT_EVENT_IN,
  input  wire logic               EVENT_STROBE_IN,
  // Interrupt and management stream.
  output logic                    EVENT_LOG_IRQ_N_OUT,
  output logic                    MGMT_FRAME_OUT,
  output logic                    MGMT_DATA_OUT
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [15:0] pin_meta_r;
  logic [15:0] pin_sync_r;
  logic        rd_req;
  logic        wr_req;
  logic [4:0]  acc_addr;
  logic [7:0]  acc_wdata;
  logic [12:0] acc_word_r;

  // Strobes, address and data pass the same two stages, so they stay aligned.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pin_meta_r <= 16'hC000;
      pin_sync_r <= 16'hC000;
    end else begin
      pin_meta_r <= {RD_N_IN, WR_N_IN, ADDR_IN, DATA_IN, 1'b0};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign rd_req    = ~pin_sync_r[15];
  assign wr_req    = ~pin_sync_r[14];
  // Keep the last synced word seen with a strobe low; write data only reaches the pins
  // once the transceiver is open, so the write is taken from this word at the end.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      acc_word_r <= '0;
    end else if (rd_req || wr_req) begin
      acc_word_r <= pin_sync_r[13:1];
    end
  end

  assign acc_addr  = acc_word_r[12:8];
  assign acc_wdata = acc_word_r[7:0];

  // ****************************************************************
  // Sequencer state and display scan.
  // ****************************************************************
  hpsd_state_type state_r;
  hpsd_state_type state_nxt;
  logic [3:0]     scan_r;
  logic           acc_start;
  logic           acc_is_read_r;
  logic           acc_commit;

  assign acc_start  = (state_r == HPSD_ACC_START);
  assign acc_commit = (state_r == HPSD_ACC_WAIT) && !(rd_req || wr_req);  // Last cycle of an access.

  // A pending access is only taken at the end of a display cycle, never inside one.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HPSD_DSP_SETUP:  state_nxt = HPSD_DSP_STROBE;
      HPSD_DSP_STROBE: state_nxt = HPSD_DSP_HOLD;
      HPSD_DSP_HOLD:   state_nxt = (rd_req || wr_req) ? HPSD_ACC_START : HPSD_DSP_SETUP;
      HPSD_ACC_START:  state_nxt = HPSD_ACC_WAIT;
      HPSD_ACC_WAIT:   state_nxt = (rd_req || wr_req) ? HPSD_ACC_WAIT : HPSD_DSP_SETUP;
      default:         state_nxt = HPSD_DSP_SETUP;
    endcase
  end

  // State register.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r <= HPSD_DSP_SETUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The scan walks all fourteen latch addresses and wraps, so LEDs track status.
  // It steps at the end of the strobe, so the byte is steady from setup through hold.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      scan_r <= 4'h0;
    end else if (state_r == HPSD_DSP_STROBE) begin
      scan_r <= (scan_r == HPSD_SCAN_LAST) ? 4'h0 : scan_r + 4'h1;
    end
  end

  // Read or write is decided once, when the access is taken.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      acc_is_read_r <= 1'b0;
    end else if (state_r == HPSD_DSP_HOLD) begin
      acc_is_read_r <= rd_req;
    end
  end

  // ****************************************************************
  // Display byte: latch address in D7-D5, status in D4-D0.
  // ****************************************************************
  logic [2:0] latch_select_address;
  logic [4:0] disp_status;
  logic [3:0] port_idx;

  assign latch_select_address = (scan_r >= HPSD_SCAN_BANK_B) ? 3'(scan_r - HPSD_SCAN_BANK_B) : scan_r[2:0];
  assign port_idx             = scan_r - 4'h1;  // Scan step n shows port n.

  always_comb begin
    disp_status = 5'h00;
    if (scan_r == 4'h0) begin
      disp_status[1] = |PORT_COLLISION_IN;  // Global collision indicator.
      disp_status[2] = |PORT_RECEIVE_IN;    // Global receive indicator.
      disp_status[3] = GLOBAL_BABBLE_IN;    // Global babble indicator.
    end else if (32'(port_idx) < NPORT) begin
      disp_status[0] = PORT_LINK_IN[port_idx];
      disp_status[1] = PORT_COLLISION_IN[port_idx];
      disp_status[2] = PORT_RECEIVE_IN[port_idx];
      disp_status[3] = PORT_ISOLATED_IN[port_idx];
      disp_status[4] = PORT_REVERSED_POLARITY_IN[port_idx];
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [7:0] control_r;
  logic [7:0] count_mask_r;
  logic [7:0] rec_mask_r;
  logic [7:0] irq_mask_r;
  logic       cfg_wr;

  assign cfg_wr = acc_commit && !acc_is_read_r;

  // Software masks choose which events count and which are recorded.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      control_r    <= HPSD_CONTROL_RST;
      count_mask_r <= HPSD_MASK_RST;
      rec_mask_r   <= HPSD_MASK_RST;
      irq_mask_r   <= HPSD_MASK_RST;
    end else if (cfg_wr) begin
      if (acc_addr == HPSD_OFS_CONTROL)    control_r    <= acc_wdata;
      if (acc_addr == HPSD_OFS_COUNT_MASK) count_mask_r <= acc_wdata;
      if (acc_addr == HPSD_OFS_REC_MASK)   rec_mask_r   <= acc_wdata;
      if (acc_addr == HPSD_OFS_IRQ_MASK)   irq_mask_r   <= acc_wdata;
    end
  end

  // ****************************************************************
  // Array decode for counters (page 0) and records (page 1).
  // ****************************************************************
  logic [4:0] arr_idx;
  logic       in_array;
  logic [3:0] cnt_port;
  logic       cnt_byte;
  logic       cnt_hit;
  logic       rec_hit;

  assign arr_idx  = acc_addr - HPSD_OFS_ARRAY;
  assign in_array = (acc_addr >= HPSD_OFS_ARRAY);
  assign cnt_port = arr_idx[4:1];
  assign cnt_byte = arr_idx[0];
  assign cnt_hit  = in_array && !control_r[HPSD_CTL_PAGE_BIT] && (32'(cnt_port) < NPORT);
  assign rec_hit  = in_array && control_r[HPSD_CTL_PAGE_BIT] && (32'(arr_idx) < NPORT);

  // ****************************************************************
  // Per-port counters and record registers.
  // ****************************************************************
  logic [15:0]     cnt_r [NPORT];
  logic [NEV-1:0]  rec_r [NPORT];
  logic [NPORT-1:0] full_v;
  logic [NPORT-1:0] high_v;
  logic [NPORT-1:0] low_v;
  logic [NPORT-1:0] rec_v;
  logic            hold_fetch;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_port
      logic [NEV-1:0] ev;
      logic           up;
      logic           sel_cnt;
      logic           sel_rec;

      assign ev      = PORT_EVENT_IN[gp*NEV +: NEV];
      assign up      = EVENT_STROBE_IN && |(ev & count_mask_r);
      assign sel_cnt = cnt_hit && (32'(cnt_port) == gp);
      assign sel_rec = acc_start && acc_is_read_r && rec_hit && (32'(arr_idx) == gp);

      // Each port owns a 16-bit counter; host writes win over counting.
      always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          cnt_r[gp] <= HPSD_CNT_RST;
        end else if (sel_cnt && cfg_wr) begin
          if (cnt_byte) cnt_r[gp][15:8] <= acc_wdata;
          else          cnt_r[gp][7:0]  <= acc_wdata;
        end else if (sel_cnt && acc_start && acc_is_read_r && hold_fetch && control_r[HPSD_CTL_ROR_BIT]) begin
          cnt_r[gp] <= up ? 16'h0001 : HPSD_CNT_RST;  // An event in the clearing cycle is kept.
        end else if (up && !(control_r[HPSD_CTL_FWF_BIT] && full_v[gp])) begin
          cnt_r[gp] <= cnt_r[gp] + 16'h0001;
        end
      end

      // Record bits are sticky; a new event in the read cycle survives the clear.
      always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          rec_r[gp] <= '0;
        end else begin
          rec_r[gp] <= (sel_rec ? '0 : rec_r[gp]) | (EVENT_STROBE_IN ? (ev & rec_mask_r) : '0);
        end
      end

      assign full_v[gp] = (cnt_r[gp] == HPSD_CNT_FULL);
      assign high_v[gp] = (cnt_r[gp] >= HPSD_CNT_HIGH);
      assign low_v[gp]  = (cnt_r[gp] <= HPSD_CNT_LOW);
      assign rec_v[gp]  = |rec_r[gp];
    end
  endgenerate

  // ****************************************************************
  // Holding register: both counter bytes are frozen at the first read.
  // ****************************************************************
  logic [15:0] hold_r;
  logic [3:0]  hold_port_r;
  logic        hold_byte_r;
  logic        hold_valid_r;

  // The second byte of a pair comes from the hold; anything else refetches.
  assign hold_fetch = !(hold_valid_r && hold_port_r == cnt_port && hold_byte_r != cnt_byte);

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      hold_r       <= HPSD_CNT_RST;
      hold_port_r  <= 4'h0;
      hold_byte_r  <= 1'b0;
      hold_valid_r <= 1'b0;
    end else if (acc_start && acc_is_read_r && cnt_hit) begin
      if (hold_fetch) begin
        hold_r       <= cnt_r[cnt_port];
        hold_port_r  <= cnt_port;
        hold_byte_r  <= cnt_byte;
        hold_valid_r <= 1'b1;
      end else begin
        hold_valid_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  logic [7:0]  rd_val;
  logic [15:0] cnt_src;
  logic [7:0]  status_val;

  assign status_val = {4'h0, |rec_v, |low_v, |high_v, |full_v};
  assign cnt_src    = hold_fetch ? cnt_r[cnt_port] : hold_r;

  // Unmapped addresses read as zero.
  always_comb begin
    rd_val = 8'h00;
    if (acc_addr == HPSD_OFS_CONTROL)         rd_val = control_r;
    else if (acc_addr == HPSD_OFS_COUNT_MASK) rd_val = count_mask_r;
    else if (acc_addr == HPSD_OFS_REC_MASK)   rd_val = rec_mask_r;
    else if (acc_addr == HPSD_OFS_IRQ_MASK)   rd_val = irq_mask_r;
    else if (acc_addr == HPSD_OFS_STATUS)     rd_val = status_val;
    else if (cnt_hit)                         rd_val = cnt_byte ? cnt_src[15:8] : cnt_src[7:0];
    else if (rec_hit)                         rd_val = 8'(rec_r[arr_idx[3:0]]);
  end

  // ****************************************************************
  // Data pins, transceiver enable and latch strobes.
  // ****************************************************************
  // The bus is driven through every display state, so the device masters it then.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      DATA_OUT      <= 8'h00;
      DATA_OE_N_OUT <= 1'b1;
    end else begin
      case (state_nxt)
        HPSD_DSP_SETUP, HPSD_DSP_STROBE, HPSD_DSP_HOLD: begin
          DATA_OUT      <= {latch_select_address, disp_status};
          DATA_OE_N_OUT <= 1'b0;
        end
        HPSD_ACC_START: begin
          DATA_OUT      <= 8'h00;
          DATA_OE_N_OUT <= ~rd_req;  // Drivers off for a write to avoid contention.
        end
        HPSD_ACC_WAIT: begin
          if (acc_start) DATA_OUT <= rd_val;
          DATA_OE_N_OUT <= ~acc_is_read_r;
        end
        default: begin
          DATA_OUT      <= 8'h00;
          DATA_OE_N_OUT <= 1'b1;
        end
      endcase
    end
  end

  // The transceiver opens only once the display cycle has ended.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      TRANSCEIVER_ENABLE_N_OUT <= 1'b1;
    end else begin
      TRANSCEIVER_ENABLE_N_OUT <= !(state_nxt == HPSD_ACC_START || state_nxt == HPSD_ACC_WAIT);
    end
  end

  // One strobe per display cycle, to the bank that owns the current address.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      FIRST_BANK_LATCH_STROBE_N_OUT  <= 1'b1;
      SECOND_BANK_LATCH_STROBE_N_OUT <= 1'b1;
    end else begin
      FIRST_BANK_LATCH_STROBE_N_OUT  <= !(state_nxt == HPSD_DSP_STROBE && scan_r < HPSD_SCAN_BANK_B);
      SECOND_BANK_LATCH_STROBE_N_OUT <= !(state_nxt == HPSD_DSP_STROBE && scan_r >= HPSD_SCAN_BANK_B);
    end
  end

  // ****************************************************************
  // Event interrupt.
  // ****************************************************************
  // Level output: stays low while any enabled source stands.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      EVENT_LOG_IRQ_N_OUT <= 1'b1;
    end else begin
      EVENT_LOG_IRQ_N_OUT <= ~|(status_val & irq_mask_r);
    end
  end

  // ****************************************************************
  // Management stream: a frame of per-port receive and collision bits.
  // ****************************************************************
  logic [2*NPORT-1:0] mgmt_shift_r;
  logic [4:0]         mgmt_cnt_r;

  // Loaded at each end-of-packet strobe; a strobe mid-frame restarts it, a simple trade
  // that keeps the newest status rather than queueing frames.
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mgmt_shift_r   <= '0;
      mgmt_cnt_r     <= 5'h00;
      MGMT_FRAME_OUT <= 1'b0;
      MGMT_DATA_OUT  <= 1'b0;
    end else if (EVENT_STROBE_IN) begin
      mgmt_shift_r   <= {PORT_COLLISION_IN, PORT_RECEIVE_IN};
      mgmt_cnt_r     <= 5'(2*NPORT);
      MGMT_FRAME_OUT <= 1'b0;
      MGMT_DATA_OUT  <= 1'b0;
    end else if (mgmt_cnt_r != 5'h00) begin
      MGMT_DATA_OUT  <= mgmt_shift_r[0];
      MGMT_FRAME_OUT <= 1'b1;
      mgmt_shift_r   <= mgmt_shift_r >> 1;
      mgmt_cnt_r     <= mgmt_cnt_r - 5'h01;
    end else begin
      MGMT_FRAME_OUT <= 1'b0;
      MGMT_DATA_OUT  <= 1'b0;
    end
  end

endmodule // hpsd_top

/* verification/hpsd_host_model.sv */
// Host processor with its glue logic, seen from the device pins.
// Assumes one access at a time, started by the bench through the acc task.
`timescale 1ns/100ps
module hpsd_host_model (
  // Clock and device outputs.
  input  wire logic       clk_in,
  input  wire logic       en_n_in,
  input  wire logic       oe_n_in,
  input  wire logic [7:0] dout_in,
  // Host side of the pins.
  output logic      [4:0] addr_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic      [7:0] din_out
);
  logic       drv_r;
  logic [7:0] wdat_r;
  logic [7:0] last_r;
  // An undriven bus shows a changing pattern, never a held value.
  always_ff @(posedge clk_in) last_r <= din_out;
  // The transceiver passes host data only when enabled and writing.
  assign din_out = !oe_n_in ? dout_in : (drv_r && !en_n_in) ? wdat_r : ~last_r;
  initial begin
    addr_out = 5'h00;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    drv_r = 1'b0;
    wdat_r = 8'h00;
  end
  // One access: strobe low, wait for the enable, take data, release.
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] wd,
                     output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge clk_in);
    addr_out <= a;
    wdat_r <= wd;
    drv_r <= wr;
    if (wr) wr_n_out <= 1'b0;
    else rd_n_out <= 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_in);
      ok = !en_n_in;
    end
    repeat (2) @(posedge clk_in);
    rd = dout_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    for (n = 0; n < 20 && !en_n_in; n++) @(posedge clk_in);
    if (!en_n_in) ok = 1'b0;
    drv_r <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule // hpsd_host_model

/* verification/hpsd_top_props.sv */
// Checker of the host port and display sequencer, bound to the top module.
// Assumes the host holds each strobe until the transceiver enable answers.
`timescale 1ns/100ps
module hpsd_top_checker (
  // Clock and reset.
  input wire logic       CLOCK_IN,
  input wire logic       RSTN_IN,
  // Host port and display pins.
  input wire logic       RD_N_IN,
  input wire logic       WR_N_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE_N_OUT,
  input wire logic       TRANSCEIVER_ENABLE_N_OUT,
  input wire logic       FIRST_BANK_LATCH_STROBE_N_OUT,
  input wire logic       SECOND_BANK_LATCH_STROBE_N_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  // ****
  // Access steps: request, grant within the sync and display latency.
  // ****
  sequence s_req;
    $fell(RD_N_IN) || $fell(WR_N_IN);
  endsequence
  sequence s_grant;
    ##[2:7] !TRANSCEIVER_ENABLE_N_OUT;
  endsequence
  a_grant_bound: assert property (s_req |-> s_grant)
    else $error("transceiver enable late after strobe");
  a_release_bound: assert property ($rose(RD_N_IN) || $rose(WR_N_IN) |-> ##[1:6] TRANSCEIVER_ENABLE_N_OUT)
    else $error("transceiver enable held after strobe");
  a_access_quiet: assert property (!TRANSCEIVER_ENABLE_N_OUT |->
    FIRST_BANK_LATCH_STROBE_N_OUT && SECOND_BANK_LATCH_STROBE_N_OUT)
    else $error("latch strobe during host access");
  a_write_undriven: assert property (!TRANSCEIVER_ENABLE_N_OUT && !WR_N_IN |-> DATA_OE_N_OUT)
    else $error("data drivers on during write");
  a_read_drive: assert property ($fell(TRANSCEIVER_ENABLE_N_OUT) && !RD_N_IN |->
    !DATA_OE_N_OUT ##1 !DATA_OE_N_OUT)
    else $error("read data not driven");
  // ****
  // Display cycles: bus master, single strobe pulses, legal addresses.
  // ****
  a_disp_drives: assert property (!FIRST_BANK_LATCH_STROBE_N_OUT || !SECOND_BANK_LATCH_STROBE_N_OUT |->
    !DATA_OE_N_OUT && TRANSCEIVER_ENABLE_N_OUT)
    else $error("display strobe without bus drive");
  a_strobe_pulse: assert property (!FIRST_BANK_LATCH_STROBE_N_OUT || !SECOND_BANK_LATCH_STROBE_N_OUT |=>
    FIRST_BANK_LATCH_STROBE_N_OUT && SECOND_BANK_LATCH_STROBE_N_OUT)
    else $error("latch strobe longer than one cycle");
  a_bank_excl: assert property (FIRST_BANK_LATCH_STROBE_N_OUT || SECOND_BANK_LATCH_STROBE_N_OUT)
    else $error("both latch strobes low");
  a_bankb_range: assert property (!SECOND_BANK_LATCH_STROBE_N_OUT |-> DATA_OUT[7:5] <= 3'h5)
    else $error("second bank address out of range");
  a_scan_alive: assert property ($fell(FIRST_BANK_LATCH_STROBE_N_OUT) |->
    ##[1:1000] $fell(FIRST_BANK_LATCH_STROBE_N_OUT))
    else $error("display scan stalled");
endmodule // hpsd_top_checker
bind hpsd_top hpsd_top_checker u_chk (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .RD_N_IN(RD_N_IN),
  .WR_N_IN(WR_N_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT),
  .TRANSCEIVER_ENABLE_N_OUT(TRANSCEIVER_ENABLE_N_OUT),
  .FIRST_BANK_LATCH_STROBE_N_OUT(FIRST_BANK_LATCH_STROBE_N_OUT),
  .SECOND_BANK_LATCH_STROBE_N_OUT(SECOND_BANK_LATCH_STROBE_N_OUT));

/* verification/host_port_and_status_display_tb.sv */
// Self-checking bench: display scan, register access, events and the serial stream.
// Assumes the host model for pin accesses and steady port status after reset.
`timescale 1ns/100ps
module host_port_and_status_display_tb;
  localparam logic [12:0] LNK = 13'h1A5B, COL = 13'h0813, PORT_RECEIVE_INDICATOR = 13'h1264, ISO = 13'h00C1, POL = 13'h1402;
  localparam logic [103:0] EV_PAT = (104'h03 << 16) | (104'h02 << 40);
  logic         clk, rstn, evs, irqn, ten_n, oe_n, s1_n, s2_n, mframe, mdata, rd_n, wr_n;
  logic [4:0]   addr;
  logic [7:0]   din, dout;
  logic [103:0] ev;
  logic [15:0]  seen;
  int           mismatches, total_checks;
  hpsd_top dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n), .TRANSCEIVER_ENABLE_N_OUT(ten_n),
    .FIRST_BANK_LATCH_STROBE_N_OUT(s1_n), .SECOND_BANK_LATCH_STROBE_N_OUT(s2_n),
    .PORT_LINK_IN(LNK), .PORT_COLLISION_IN(COL), .PORT_RECEIVE_IN(PORT_RECEIVE_INDICATOR), .PORT_ISOLATED_IN(ISO),
    .PORT_REVERSED_POLARITY_IN(POL), .GLOBAL_BABBLE_IN(1'b1), .PORT_EVENT_IN(ev),
    .EVENT_STROBE_IN(evs), .EVENT_LOG_IRQ_N_OUT(irqn), .MGMT_FRAME_OUT(mframe), .MGMT_DATA_OUT(mdata));
  hpsd_host_model host (.clk_in(clk), .en_n_in(ten_n), .oe_n_in(oe_n), .dout_in(dout),
    .addr_out(addr), .rd_n_out(rd_n), .wr_n_out(wr_n), .din_out(din));
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [25:0] e, input logic [25:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // A host access that never completes ends the run at once.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] v);
    logic ok;
    host.acc(wr, a, d, v, ok);
    if (!ok) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    xfer(1'b0, a, 8'h00, v);
    chk("register read", 26'(e), 26'(v));
  endtask
  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    xfer(1'b1, a, d, v);
  endtask
  // Latch 0 of the first bank holds the global indicators, the rest one port each.
  function automatic logic [4:0] exp_disp(input int i);
    if (i == 0) return {1'b0, 1'b1, |PORT_RECEIVE_INDICATOR, |COL, 1'b0};
    return {POL[i-1], ISO[i-1], PORT_RECEIVE_INDICATOR[i-1], COL[i-1], LNK[i-1]};
  endfunction
  // Every latch strobe is checked against the steady port status.
  always @(posedge clk) begin
    if (rstn && !s1_n) begin
      chk("first bank byte", 26'(exp_disp(int'(dout[7:5]))), 26'(dout[4:0]));
      seen[dout[7:5]] = 1'b1;
    end
    if (rstn && !s2_n) begin
      chk("second bank byte", 26'(exp_disp(8 + int'(dout[7:5]))), 26'(dout[4:0]));
      seen[4'h8 + 4'(dout[7:5])] = 1'b1;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    logic [25:0] mg;
    int n;
    rstn = 1'b0;
    evs = 1'b0;
    ev = '0;
    seen = 16'h0000;
    mg = '0;
    n = 0;
    repeat (20) @(posedge clk);
    chk("reset outputs", 26'h1F, 26'({ten_n, oe_n, s1_n, s2_n, irqn}));
    rstn <= 1'b1;
    repeat (50) @(posedge clk);
    rdc(5'h00, 8'h00);
    rdc(5'h01, 8'h00);
    wrr(5'h01, 8'h5A);
    rdc(5'h01, 8'h5A);
    rdc(5'h05, 8'h00);
    rdc(5'h04, 8'h04);
    wrr(5'h01, 8'h01);
    wrr(5'h02, 8'h02);
    wrr(5'h03, 8'h08);
    // One end-of-packet event: port 2 counts and records, port 5 only records.
    @(posedge clk);
    ev <= EV_PAT;
    evs <= 1'b1;
    @(posedge clk);
    evs <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (mframe) begin
        mg[n] = mdata;
        n++;
      end
    end
    chk("serial bit count", 26'(26), 26'(n));
    chk("serial bits", {COL, PORT_RECEIVE_INDICATOR}, mg);
    chk("event interrupt", 26'h0, 26'(irqn));
    rdc(5'h0A, 8'h01);
    rdc(5'h0B, 8'h00);
    rdc(5'h10, 8'h00);
    wrr(5'h00, 8'h01);
    rdc(5'h08, 8'h02);
    rdc(5'h0B, 8'h02);
    rdc(5'h08, 8'h00);
    wrr(5'h00, 8'h02);
    rdc(5'h0A, 8'h01);
    rdc(5'h0A, 8'h00);
    chk("interrupt cleared", 26'h1, 26'(irqn));
    repeat (50) @(posedge clk);
    chk("latch addresses visited", 26'h3FFF, 26'(seen));
    give_verdict();
  end
endmodule // host_port_and_status_display_tb
